// ===== logic/sub_tick_sync.sv
/*
  Turns the slow sub clock pin into a one-cycle tick on clk.
  Assumes sub_clk is asynchronous and much slower than clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sub_tick_sync
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sub_clk,
  output logic tick
);
  logic s1_q, s2_q, s3_q;

  // two-stage synchroniser, edge taken from its second stage and the stage after it
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= sub_clk;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign tick = s2_q & ~s3_q;
endmodule
`default_nettype wire

// ===== logic/wdt_reset_ctrl.sv
/*
  Watchdog timer and reset-cause control with an AHB-Lite slave.
  Assumes the core supplies clear/halt pulses, sleep and power-down levels,
  and a raw low-supply level and the sub clock from pins.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - watchdog overflow while running resets the device unless software clears it first
// - enable key 10101 disables the watchdog
// - enable key 01010 enables counting
// - any other key resets after two to three sub clock ticks
// - enable key comes up as 01010 after power-on
// - running time-out gives full reset and sets time-out flag
// - sleeping time-out sets flag and resets only counter and stack
// - bad key reset, clear instruction or halt clears the counter
// - period spans 2^8 to 2^18 sub clocks
// - power-on forces program counter to zero
// - power-on sets port data and direction to all ones
// - power-on or low-voltage reset holds for 50 ms
// - running watchdog reset holds for 16.7 ms
// - low-voltage monitor on except in power-down, sets its flag and resets
// - low-supply shorter than qualify time is ignored
// - only four threshold codes are legal, 0x55 default
// - other code resets, sets threshold flag, restores default
// - genuine low-voltage reset keeps threshold register
// - threshold register is 0x55 at power-on
// - low-voltage reset disabled in power-down
// - reset flags set by hardware, cleared only by software write 0
// - reset-cause bits 6 to 3 read zero
// - period select maps 000..111 to 2^8,10,12,14,15,16,17,18
// - bad watchdog key sets watchdog-key flag
// - power-on clears time-out and power-down; sleep time-out sets both
module wdt_reset_ctrl
  import wdt_reset_pkg::*;
#(
  parameter int por_cycles = wdt_reset_pkg::por_delay_cyc,
  parameter int wdt_cycles = wdt_reset_pkg::wdt_delay_cyc,
  parameter int lv_qual_cycles = 64
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sub_clk,
  input wire logic low_supply,
  input wire logic clear_instr,
  input wire logic halt_instr,
  input wire logic sleeping,
  input wire logic power_down,
  output logic core_rst,
  output logic pc_sp_rst,
  output logic [7:0] port_data_init,
  output logic [7:0] port_dir_init,
  output logic idle_system_clock_keep
);
  import wdt_reset_pkg::*;

  // ****************************************
  // sub clock tick and low-supply synchroniser
  // ****************************************
  logic sub_tick;
  logic lv1_q, lv2_q;

  sub_tick_sync u_sync
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .sub_clk(sub_clk),
    .tick(sub_tick)
  );

  // supply sense is asynchronous to clk
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lv1_q <= 1'b0;
      lv2_q <= 1'b0;
    end
    else
    begin
      lv1_q <= low_supply;
      lv2_q <= lv1_q;
    end
  end

  // ****************************************
  // AHB-Lite address phase capture
  // ****************************************
  logic wr_pend_q, wr_pend_d;
  logic [11:0] wr_addr_q, wr_addr_d;
  logic rd_pend_q, rd_pend_d;
  logic [11:0] rd_addr_q, rd_addr_d;
  logic phase_ok;

  assign phase_ok = hsel & hready & htrans[1];

  // zero wait states, so the slave is always ready and always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // latch address phase for the following data phase
  always_comb
  begin
    wr_pend_d = phase_ok & hwrite;
    rd_pend_d = phase_ok & ~hwrite;
    wr_addr_d = haddr[11:0];
    rd_addr_d = haddr[11:0];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rd_addr_q <= 12'h000;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      wr_addr_q <= wr_addr_d;
      rd_addr_q <= rd_addr_d;
    end
  end

  // ****************************************
  // registers and watchdog state
  // ****************************************
  logic [7:0] wdog_ctrl_q, wdog_ctrl_d;
  logic [7:0] lv_thr_q, lv_thr_d;
  logic [2:0] flags_q, flags_d;
  logic keep_q, keep_d;
  logic to_q, to_d;
  logic pdf_q, pdf_d;
  logic [wdt_width-1:0] wcnt_q, wcnt_d;
  logic [1:0] wkey_cnt_q, wkey_cnt_d;
  logic [1:0] lkey_cnt_q, lkey_cnt_d;
  logic [$clog2(lv_qual_cycles+1)-1:0] lvq_q, lvq_d;
  logic [31:0] hold_q, hold_d;
  rst_state_t st_q, st_d;
  logic [2:0] psel;
  logic key_ok, lv_ok, wen, ovf_bit, wdt_ovf;
  logic wkey_rst, lkey_rst, lv_rst, wdt_run_rst, wdt_sleep_rst;
  logic wr_wd, wr_lv, wr_rc, in_hold;
  logic [4:0] key;

  assign key = wdog_ctrl_q[7:3];
  assign psel = wdog_ctrl_q[2:0];
  assign key_ok = (key == key_enable) || (key == key_disable);
  assign wen = (key == key_enable);
  assign in_hold = (st_q == hold_st);

  // legal threshold codes
  assign lv_ok = (lv_thr_q == lv_code_2v10) || (lv_thr_q == lv_code_2v55) ||
                 (lv_thr_q == lv_code_3v15) || (lv_thr_q == lv_code_3v80);

  // overflow tap picked by period select
  always_comb
  begin
    unique case (psel)
      3'd0: ovf_bit = &wcnt_q[7:0];
      3'd1: ovf_bit = &wcnt_q[9:0];
      3'd2: ovf_bit = &wcnt_q[11:0];
      3'd3: ovf_bit = &wcnt_q[13:0];
      3'd4: ovf_bit = &wcnt_q[14:0];
      3'd5: ovf_bit = &wcnt_q[15:0];
      3'd6: ovf_bit = &wcnt_q[16:0];
      3'd7: ovf_bit = &wcnt_q[17:0];
    endcase
  end

  // time-out on the tick that carries out of the selected width: exactly 2^k ticks
  assign wdt_ovf = wen & sub_tick & ovf_bit & ~in_hold;
  assign wdt_run_rst = wdt_ovf & ~sleeping;
  assign wdt_sleep_rst = wdt_ovf & sleeping;
  assign wkey_rst = ~key_ok & sub_tick & (wkey_cnt_q == 2'(key_bad_min_sub));
  assign lkey_rst = ~lv_ok & sub_tick & (lkey_cnt_q == 2'(key_bad_min_sub));
  assign lv_rst = ~power_down & (32'(lvq_q) == lv_qual_cycles);

  assign wr_wd = wr_pend_q & (wr_addr_q == wdog_ctrl_off);
  assign wr_lv = wr_pend_q & (wr_addr_q == lv_thresh_off);
  assign wr_rc = wr_pend_q & (wr_addr_q == rst_cause_off);

  // next state for all registers and counters
  always_comb
  begin
    wdog_ctrl_d = wr_wd ? hwdata[7:0] : wdog_ctrl_q;
    lv_thr_d = wr_lv ? hwdata[7:0] : lv_thr_q;
    keep_d = wr_rc ? hwdata[keep_clk_pos] : keep_q;
    // software may only clear; a same-cycle hardware set still wins
    flags_d = wr_rc ? (flags_q & hwdata[2:0]) : flags_q;
    to_d = to_q;
    pdf_d = pdf_q;
    wcnt_d = (wen && sub_tick && !in_hold) ? wcnt_q + 1'b1 : wcnt_q;
    wkey_cnt_d = key_ok ? 2'd0 : (sub_tick ? wkey_cnt_q + 2'd1 : wkey_cnt_q);
    lkey_cnt_d = lv_ok ? 2'd0 : (sub_tick ? lkey_cnt_q + 2'd1 : lkey_cnt_q);
    lvq_d = (lv2_q && !power_down) ?
            ((32'(lvq_q) == lv_qual_cycles) ? lvq_q : lvq_q + 1'b1) : '0;
    hold_d = (hold_q != 32'd0) ? hold_q - 32'd1 : 32'd0;
    st_d = st_q;
    if (clear_instr)
    begin
      wcnt_d = '0;
      to_d = 1'b0;
      pdf_d = 1'b0;
    end
    if (halt_instr)
    begin
      wcnt_d = '0;
      to_d = 1'b0;
      pdf_d = 1'b1;
    end
    if (wdt_sleep_rst)
    begin
      wcnt_d = '0;
      to_d = 1'b1;
      pdf_d = 1'b1;
    end
    if (wdt_run_rst)
    begin
      wcnt_d = '0;
      to_d = 1'b1;
      wdog_ctrl_d = wdog_ctrl_rst;
      lv_thr_d = lv_thresh_rst;
      hold_d = 32'(wdt_cycles);
      st_d = hold_st;
    end
    if (wkey_rst)
    begin
      wcnt_d = '0;
      flags_d[flag_wrf_pos] = 1'b1;
      wdog_ctrl_d = wdog_ctrl_rst;
      hold_d = 32'(wdt_cycles);
      st_d = hold_st;
    end
    if (lkey_rst)
    begin
      flags_d[flag_lrf_pos] = 1'b1;
      lv_thr_d = lv_thresh_rst;
      wcnt_d = '0;
      hold_d = 32'(wdt_cycles);
      st_d = hold_st;
    end
    if (lv_rst)
    begin
      flags_d[flag_lv_pos] = 1'b1;
      lv_thr_d = lv_thr_q;
      wdog_ctrl_d = wdog_ctrl_rst;
      wcnt_d = '0;
      hold_d = 32'(por_cycles);
      st_d = hold_st;
    end
    if (st_q == hold_st && hold_q == 32'd0 && !lv_rst)
    begin
      st_d = run_st;
    end
  end

  // power-on: enable key, threshold and flag defaults
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wdog_ctrl_q <= wdog_ctrl_rst;
      lv_thr_q <= lv_thresh_rst;
      flags_q <= 3'b000;
      keep_q <= 1'b0;
      to_q <= 1'b0;
      pdf_q <= 1'b0;
      wcnt_q <= '0;
      wkey_cnt_q <= 2'd0;
      lkey_cnt_q <= 2'd0;
      lvq_q <= '0;
      hold_q <= 32'(por_cycles);
      st_q <= hold_st;
    end
    else
    begin
      wdog_ctrl_q <= wdog_ctrl_d;
      lv_thr_q <= lv_thr_d;
      flags_q <= flags_d;
      keep_q <= keep_d;
      to_q <= to_d;
      pdf_q <= pdf_d;
      wcnt_q <= wcnt_d;
      wkey_cnt_q <= wkey_cnt_d;
      lkey_cnt_q <= lkey_cnt_d;
      lvq_q <= lvq_d;
      hold_q <= hold_d;
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs and read mux
  // ****************************************
  logic [31:0] rdata_d;
  logic pcsp_q, pcsp_d;

  // pc/sp pulse: only a sleeping time-out uses it; core_rst covers the rest
  always_comb
  begin
    pcsp_d = wdt_sleep_rst;
    rdata_d = 32'h0;
    if (rd_pend_d)
    begin
      unique case (haddr[11:0])
        wdog_ctrl_off: rdata_d = {24'h0, wdog_ctrl_d};
        lv_thresh_off: rdata_d = {24'h0, lv_thr_d};
        rst_cause_off: rdata_d = {24'h0, keep_d, 4'h0, flags_d};
        status_off: rdata_d = {30'h0, pdf_d, to_d};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hrdata <= 32'h0;
      pcsp_q <= 1'b0;
    end
    else
    begin
      hrdata <= rdata_d;
      pcsp_q <= pcsp_d;
    end
  end

  assign core_rst = in_hold;
  assign pc_sp_rst = pcsp_q | in_hold;
  assign port_data_init = in_hold ? 8'hff : 8'h00;
  assign port_dir_init = in_hold ? 8'hff : 8'h00;
  assign idle_system_clock_keep = keep_q;

  // ****************************************
  // checks
  // ****************************************
  a_flag_wins_clear: assert property (@(posedge clk) disable iff (sys_rst)
    wkey_rst |=> flags_q[flag_wrf_pos] && core_rst)
    else $error("watchdog key flag or reset missing");
  a_sleep_no_core: assert property (@(posedge clk) disable iff (sys_rst)
    (wdt_sleep_rst && !in_hold && !lv_rst && !wkey_rst && !lkey_rst) |=>
    to_q && pdf_q && !core_rst && pc_sp_rst)
    else $error("sleep time-out handled wrong");
  a_run_timeout: assert property (@(posedge clk) disable iff (sys_rst)
    wdt_run_rst |=> to_q && core_rst)
    else $error("running time-out did not reset");
  a_disabled_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (key == key_disable) |-> !wdt_ovf)
    else $error("disabled watchdog timed out");
  a_lv_keeps_thr: assert property (@(posedge clk) disable iff (sys_rst)
    (lv_rst && !wr_lv && !lkey_rst) |=> lv_thr_q == $past(lv_thr_q))
    else $error("threshold changed on low-voltage reset");
  a_bad_thr_restore: assert property (@(posedge clk) disable iff (sys_rst)
    (lkey_rst && !wr_lv) |=> lv_thr_q == lv_thresh_rst && flags_q[flag_lrf_pos])
    else $error("bad threshold not restored");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst)
    hrdata[6:3] == 4'h0 || $past(rd_addr_d) != rst_cause_off)
    else $error("reserved bits not zero");
  a_pd_no_lv: assert property (@(posedge clk) disable iff (sys_rst)
    power_down |-> !lv_rst)
    else $error("low-voltage reset in power-down");
  a_clear_counter: assert property (@(posedge clk) disable iff (sys_rst)
    (clear_instr && !sub_tick) |=> wcnt_q == '0)
    else $error("clear did not zero counter");
  a_ports_input: assert property (@(posedge clk) disable iff (sys_rst)
    core_rst |-> port_dir_init == 8'hff)
    else $error("ports not inputs in reset");
endmodule
`default_nettype wire

// ===== logic/wdt_reset_pkg.sv
/*
  Package for the watchdog and reset-control block: register offsets,
  key codes, reset values and delay constants.
  Assumes a 50 MHz system clock and an AHB-Lite register bus.
*/
`default_nettype none

package wdt_reset_pkg;

  // ****************************************
  // register map (byte addresses, our choice)
  // ****************************************
  localparam logic [11:0] wdog_ctrl_off = 12'h000;
  localparam logic [11:0] lv_thresh_off = 12'h004;
  localparam logic [11:0] rst_cause_off = 12'h008;
  localparam logic [11:0] status_off = 12'h00c;

  // ****************************************
  // field codes and reset values
  // ****************************************
  localparam logic [4:0] key_disable = 5'h15;
  localparam logic [4:0] key_enable = 5'h0a;
  localparam logic [7:0] wdog_ctrl_rst = 8'h53;
  localparam logic [7:0] lv_code_2v10 = 8'h55;
  localparam logic [7:0] lv_code_2v55 = 8'h33;
  localparam logic [7:0] lv_code_3v15 = 8'h99;
  localparam logic [7:0] lv_code_3v80 = 8'haa;
  localparam logic [7:0] lv_thresh_rst = 8'h55;
  localparam int flag_lv_pos = 2;
  localparam int flag_lrf_pos = 1;
  localparam int flag_wrf_pos = 0;
  localparam int keep_clk_pos = 7;

  // ****************************************
  // timing
  // ****************************************
  localparam int clk_mhz = 50;
  localparam int por_delay_us = 50000;
  localparam int wdt_delay_us = 16700;
  localparam int por_delay_cyc = por_delay_us * clk_mhz;
  localparam int wdt_delay_cyc = wdt_delay_us * clk_mhz;
  localparam int key_bad_min_sub = 2;
  localparam int wdt_width = 18;

  typedef enum logic [1:0] {run_st, hold_st} rst_state_t;

endpackage

`default_nettype wire

// ===== tb/watchdog_and_reset_control_bench.sv
/*
  Self-checking bench for wdt_reset_ctrl: bus, keys, threshold, supply, time-out.
  Assumes shortened delays and a free sub clock about ten clk periods long.
*/
`timescale 1ns/1ps
`default_nettype none

module watchdog_and_reset_control_bench;
  import wdt_reset_pkg::*;
  localparam int por_n = 50;
  localparam int wdt_n = 30;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sub_clk = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic low_supply = 1'b0;
  logic clear_instr = 1'b0;
  logic halt_instr = 1'b0;
  logic sleeping = 1'b0;
  logic power_down = 1'b0;
  logic core_rst;
  logic pc_sp_rst;
  logic [7:0] port_data_init;
  logic [7:0] port_dir_init;
  logic keep_clk;
  int compares = 0;
  int miscompares = 0;
  int n;
  logic [7:0] codes [4] = '{lv_code_2v10, lv_code_2v55, lv_code_3v15, lv_code_3v80};

  // ****************************************
  // clocks and design
  // ****************************************
  // sub clock odd period keeps its phase wandering against clk
  always #10 clk = ~clk;
  always #103 sub_clk = ~sub_clk;

  wdt_reset_ctrl #(.por_cycles(por_n), .wdt_cycles(wdt_n), .lv_qual_cycles(4)) i_dut
  (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .sub_clk(sub_clk),
    .low_supply(low_supply), .clear_instr(clear_instr), .halt_instr(halt_instr),
    .sleeping(sleeping), .power_down(power_down), .core_rst(core_rst),
    .pc_sp_rst(pc_sp_rst), .port_data_init(port_data_init),
    .port_dir_init(port_dir_init), .idle_system_clock_keep(keep_clk)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // wait on hready bounded, a stuck slave ends the run
  task automatic wait_ready();
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hready !== 1'b1 && k < 16);
    if (hready !== 1'b1)
    begin
      check("hready", hready, 1'b1);
      end_sim();
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check("hresp okay", hresp, 1'b0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    check(what, d & m, exp);
  endtask

  // counts cycles until core_rst reaches v; a lost wait ends the run
  task automatic wait_core(input logic v, input int bound, output int cnt);
    cnt = 0;
    while (core_rst !== v && cnt < bound)
    begin
      @(posedge clk);
      cnt++;
    end
    if (core_rst !== v)
    begin
      check("core_rst wait", core_rst, v);
      end_sim();
    end
  endtask

  task automatic quiet(input int cyc);
    logic hit;
    hit = 1'b0;
    repeat (cyc)
    begin
      @(posedge clk);
      if (core_rst !== 1'b0)
        hit = 1'b1;
    end
    check("core_rst quiet", hit, 1'b0);
  endtask

  task automatic pulse_clear();
    @(posedge clk);
    clear_instr <= 1'b1;
    @(posedge clk);
    clear_instr <= 1'b0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    check("port data", port_data_init, 8'hff);
    check("port dir", port_dir_init, 8'hff);
    wait_core(1'b0, 200, n);
    check("por hold", n >= por_n - 4 && n <= por_n + 4, 1'b1);
    rd_chk("wdog ctrl", wdog_ctrl_off, 32'hffffffff, 32'h53);
    rd_chk("threshold", lv_thresh_off, 32'hffffffff, 32'h55);
    rd_chk("cause", rst_cause_off, 32'hfffffffb, 32'h0);
    rd_chk("status", status_off, 32'h3, 32'h0);
    wr(12'h010, 32'hff);
    rd_chk("unmapped", 12'h010, 32'hffffffff, 32'h0);
    wr(rst_cause_off, 32'hf8);
    @(posedge clk);
    check("clock keep", keep_clk, 1'b1);
    rd_chk("cause bits", rst_cause_off, 32'hf8, 32'h80);
    $display("test reset done");
  endtask

  // illegal enable key: reset, flag, flag cleared only by a zero write
  task automatic test_bad_key();
    wr(wdog_ctrl_off, 32'h1b);
    wait_core(1'b1, 60, n);
    check("bad key delay", n >= 18 && n <= 36, 1'b1);
    wait_core(1'b0, 200, n);
    rd_chk("wdog ctrl", wdog_ctrl_off, 32'hff, 32'h53);
    rd_chk("key flag", rst_cause_off, 32'h1, 32'h1);
    wr(rst_cause_off, 32'h0);
    rd_chk("flags cleared", rst_cause_off, 32'h7, 32'h0);
    wr(rst_cause_off, 32'h7);
    rd_chk("flags set by sw", rst_cause_off, 32'h7, 32'h0);
    $display("test bad key done");
  endtask

  task automatic test_threshold();
    foreach (codes[i])
    begin
      wr(lv_thresh_off, {24'h0, codes[i]});
      rd_chk("legal code", lv_thresh_off, 32'hff, {24'h0, codes[i]});
    end
    quiet(40);
    wr(lv_thresh_off, 32'h12);
    wait_core(1'b1, 60, n);
    check("bad code delay", n >= 18 && n <= 36, 1'b1);
    wait_core(1'b0, 200, n);
    rd_chk("threshold back", lv_thresh_off, 32'hff, 32'h55);
    rd_chk("thr flag", rst_cause_off, 32'h2, 32'h2);
    wr(rst_cause_off, 32'h0);
    $display("test threshold done");
  endtask

  task automatic test_low_supply();
    wr(lv_thresh_off, 32'h33);
    low_supply <= 1'b1;
    repeat (2) @(posedge clk);
    low_supply <= 1'b0;
    quiet(30);
    power_down <= 1'b1;
    low_supply <= 1'b1;
    quiet(30);
    low_supply <= 1'b0;
    power_down <= 1'b0;
    @(posedge clk);
    low_supply <= 1'b1;
    wait_core(1'b1, 40, n);
    low_supply <= 1'b0;
    wait_core(1'b0, 200, n);
    // the hold reloads until the synchronised, filtered indication has dropped
    check("lv hold", n >= por_n + 1 && n <= por_n + 9, 1'b1);
    rd_chk("threshold kept", lv_thresh_off, 32'hff, 32'h33);
    rd_chk("lv flag", rst_cause_off, 32'h4, 32'h4);
    wr(rst_cause_off, 32'h0);
    $display("test low supply done");
  endtask

  // shortest period 2^8 sub ticks: disabled, kept alive, running and sleeping time-outs
  task automatic test_timeout();
    wr(wdog_ctrl_off, 32'ha8);
    pulse_clear();
    quiet(3000);
    wr(wdog_ctrl_off, 32'h50);
    repeat (30)
    begin
      pulse_clear();
      quiet(100);
    end
    wait_core(1'b1, 4000, n);
    check("period", n > 2300 && n < 2800, 1'b1);
    check("port data", port_data_init, 8'hff);
    wait_core(1'b0, 200, n);
    check("wdt hold", n >= wdt_n - 4 && n <= wdt_n + 4, 1'b1);
    rd_chk("to flag", status_off, 32'h1, 32'h1);
    rd_chk("wdog ctrl", wdog_ctrl_off, 32'hff, 32'h53);
    sleeping <= 1'b1;
    wr(wdog_ctrl_off, 32'h50);
    pulse_clear();
    n = 0;
    while (pc_sp_rst !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    check("pc sp reset", pc_sp_rst, 1'b1);
    check("no full reset", core_rst, 1'b0);
    if (pc_sp_rst !== 1'b1)
      end_sim();
    sleeping <= 1'b0;
    rd_chk("sleep flags", status_off, 32'h3, 32'h3);
    // halt sets power-down and clears time-out
    @(posedge clk);
    halt_instr <= 1'b1;
    @(posedge clk);
    halt_instr <= 1'b0;
    rd_chk("halt flags", status_off, 32'h3, 32'h2);
    wr(wdog_ctrl_off, 32'ha8);
    $display("test timeout done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    test_reset();
    test_bad_key();
    test_threshold();
    test_low_supply();
    test_timeout();
    end_sim();
  end
endmodule

`default_nettype wire
